// File: src/vcr_defs.svh
`ifndef VCR_DEFS_SVH
`define VCR_DEFS_SVH
// What this block does
// - address zero reads zero; writes to it change nothing
// - writing one to power bit 7 resets every register; bit self-clears
// - power bits 4,3,2 enable speaker, line, handset drivers; zero powers down
// - power bit 1 high powers down microphone bias buffer
// - power bit 0 high puts whole chip into sleep
// - second control bit 4 high disables receive high-pass filter
// - second control bit 3 picks final pll divide by 10, else 5
// - second control bit 2 loops dac analog output into adc input
// - second control bit 1 loops dac bitstream into adc bitstream
// - pll registers hold factor minus one; device applies stored value plus one
// - line input gain bits 7:6, mute bit 5
// - microphone gain bits 4:3, mute bit 2
// - mixer bit 1 high mutes handset input
// - mixer bit 0 picks recursive filter when high, else fir
// - receive gain five bits 6:2, 1.5 dB per count
// - transmit gain five bits 6:2, 1.5 dB per count
// - receive volume bits 1,0 are active-low line and handset mutes
// - transmit volume bits 1,0 are active-low left and right speaker mutes
// - status read-only; bits 7,6,5 report shorts; lower bits zero
// - line output attenuation in bits 3:2, six dB steps
// - speaker output attenuation in bits 1:0, six dB steps
// - one frame per access: read/write bit, 5-bit address, 8 data bits
// - both pll registers zero means the pll is bypassed
// - host writes divider first, then multiplier at once

// register addresses
`define VCR_A_ZERO 5'h00
`define VCR_A_PWR 5'h01
`define VCR_A_FPL 5'h02
`define VCR_A_DIV 5'h03
`define VCR_A_MUL 5'h04
`define VCR_A_MIX 5'h05
`define VCR_A_RXV 5'h06
`define VCR_A_TXV 5'h07
`define VCR_A_STS 5'h08
`define VCR_A_ATT 5'h09
`define VCR_NREG 9

// writable bit masks, reserved bits are never stored
`define VCR_M_PWR 8'h1F
`define VCR_M_FPL 8'h1E
`define VCR_M_VOL 8'h7F
`define VCR_M_ATT 8'h0F

// reset values
`define VCR_R_PWR 8'h00
`define VCR_R_FPL 8'h00
`define VCR_R_PLL 8'h00
`define VCR_R_MIX 8'h47
`define VCR_R_VOL 8'h5C
`define VCR_R_ATT 8'h00
`define VCR_F_ONE 9'h001

// field positions
`define VCR_B_SRST 7
`define VCR_B_SPK 4
`define VCR_B_LINE 3
`define VCR_B_HS 2
`define VCR_B_MIC 1
`define VCR_B_SLEEP 0
`define VCR_B_HPF 4
`define VCR_B_DIV10 3
`define VCR_B_ALB 2
`define VCR_B_BLB 1

// frame bit positions
`define VCR_P_ADDR 4'd5
`define VCR_P_RD0 4'd7
`define VCR_P_RD7 4'd14
`define VCR_P_LAST 4'd15
`endif

// File: src/vcr_pkg.sv
package vcr_pkg;
  // frame receiver state
  typedef enum logic [0:0] {
    FRM_IDLE = 1'b0,
    FRM_BUSY = 1'b1
  } vcr_frm_t;
endpackage

// File: src/vcr_regs.sv
`include "vcr_defs.svh"

module vcr_regs (
  // system
  input wire logic clk,
  input wire logic srst,
  // serial control link
  input wire logic sclk,
  input wire logic frame_sync,
  input wire logic serial_data_in,
  output logic serial_data_out,
  // short detectors, asynchronous levels
  input wire logic left_speaker_short_in,
  input wire logic right_speaker_short_in,
  input wire logic line_output_short_in,
  // power control
  output logic speaker_drive_enable,
  output logic line_drive_enable,
  output logic handset_drive_enable,
  output logic mic_bias_powerdown,
  output logic chip_sleep,
  // filter, pll and loopback
  output logic highpass_disable,
  output logic pll_post_div10,
  output logic analog_loopback_select,
  output logic bitstream_loopback_select,
  output logic [8:0] pll_divide_factor,
  output logic [8:0] pll_multiply_factor,
  output logic pll_bypass,
  // input mixer
  output logic [1:0] line_input_gain,
  output logic line_input_mute,
  output logic [1:0] microphone_gain,
  output logic microphone_mute,
  output logic handset_input_mute,
  output logic recursive_filter_select,
  // volumes and mutes
  output logic [4:0] receive_gain,
  output logic line_output_active,
  output logic handset_output_active,
  output logic [4:0] transmit_gain,
  output logic left_speaker_active,
  output logic right_speaker_active,
  // attenuation
  output logic [1:0] line_output_attenuation,
  output logic [1:0] speaker_output_attenuation
);

  //////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] power_and_reset_control_ff;
  logic [7:0] filter_pll_loopback_control_ff;
  logic [7:0] pll_input_divider_ff;
  logic [7:0] pll_feedback_multiplier_ff;
  logic [7:0] input_mixer_gain_ff;
  logic [7:0] receive_volume_ff;
  logic [7:0] transmit_volume_ff;
  logic [7:0] output_attenuation_ff;
  logic [7:0] short_circuit_status;
  logic [2:0] sc_s1_ff;
  logic [2:0] sc_s2_ff;
  logic [8:0] div_fac_ff;
  logic [8:0] mul_fac_ff;
  logic bypass_ff;
  logic wr_s1_ff;
  logic wr_s2_ff;
  logic wr_s3_ff;
  logic wr_take;
  logic soft_rst;
  logic [71:0] cur_word;
  logic [71:0] snap_hold_ff;
  logic snap_req_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  // link domain
  logic lrst_s1_ff;
  logic lrst_s2_ff;
  logic req_s1_ff;
  logic req_s2_ff;
  logic snap_seen_ff;
  logic [71:0] snap_l_ff;
  vcr_pkg::vcr_frm_t state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [3:0] pos;
  logic [3:0] rd_idx;
  logic in_frm;
  logic rw_ff;
  logic [4:0] addr_ff;
  logic wr_tgl_ff;
  logic [4:0] wr_addr_l_ff;
  logic [7:0] wr_data_l_ff;
  logic [7:0] rd_word;
  logic sout_ff;

  //////////////////////////////////////////////////////////////////
  // write request from the link, toggle crossing
  // address and data stay still for a whole frame after the toggle,
  // so they are read directly once the toggle has been synchronised
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_s1_ff <= 1'b0;
      wr_s2_ff <= 1'b0;
      wr_s3_ff <= 1'b0;
    end
    else
    begin
      wr_s1_ff <= wr_tgl_ff;
      wr_s2_ff <= wr_s1_ff;
      wr_s3_ff <= wr_s2_ff;
    end
  end

  assign wr_take = wr_s2_ff ^ wr_s3_ff;
  // soft reset acts once, the bit itself is never stored
  assign soft_rst = wr_take && (wr_addr_l_ff == `VCR_A_PWR)
                    && wr_data_l_ff[`VCR_B_SRST];

  //////////////////////////////////////////////////////////////////
  // register file; reserved bits masked on write so they read zero
  always_ff @(posedge clk)
  begin
    if (srst || soft_rst)
    begin
      power_and_reset_control_ff <= `VCR_R_PWR;
      filter_pll_loopback_control_ff <= `VCR_R_FPL;
      pll_input_divider_ff <= `VCR_R_PLL;
      pll_feedback_multiplier_ff <= `VCR_R_PLL;
      input_mixer_gain_ff <= `VCR_R_MIX;
      receive_volume_ff <= `VCR_R_VOL;
      transmit_volume_ff <= `VCR_R_VOL;
      output_attenuation_ff <= `VCR_R_ATT;
    end
    else if (wr_take)
    begin
      // address zero and undefined addresses fall through untouched
      case (wr_addr_l_ff)
        `VCR_A_PWR: power_and_reset_control_ff <= wr_data_l_ff & `VCR_M_PWR;
        `VCR_A_FPL: filter_pll_loopback_control_ff <= wr_data_l_ff & `VCR_M_FPL;
        `VCR_A_DIV: pll_input_divider_ff <= wr_data_l_ff;
        `VCR_A_MUL: pll_feedback_multiplier_ff <= wr_data_l_ff;
        `VCR_A_MIX: input_mixer_gain_ff <= wr_data_l_ff;
        `VCR_A_RXV: receive_volume_ff <= wr_data_l_ff & `VCR_M_VOL;
        `VCR_A_TXV: transmit_volume_ff <= wr_data_l_ff & `VCR_M_VOL;
        `VCR_A_ATT: output_attenuation_ff <= wr_data_l_ff & `VCR_M_ATT;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////
  // pll factors take effect only on the multiplier write, so the
  // divider written just before lands together with it
  always_ff @(posedge clk)
  begin
    if (srst || soft_rst)
    begin
      div_fac_ff <= `VCR_F_ONE;
      mul_fac_ff <= `VCR_F_ONE;
      bypass_ff <= 1'b1;
    end
    else if (wr_take && (wr_addr_l_ff == `VCR_A_MUL))
    begin
      div_fac_ff <= {1'b0, pll_input_divider_ff} + `VCR_F_ONE;
      mul_fac_ff <= {1'b0, wr_data_l_ff} + `VCR_F_ONE;
      bypass_ff <= (pll_input_divider_ff == 8'h00)
                   && (wr_data_l_ff == 8'h00);
    end
  end

  //////////////////////////////////////////////////////////////////
  // short detectors come from analog, synchronise before use
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sc_s1_ff <= 3'h0;
      sc_s2_ff <= 3'h0;
    end
    else
    begin
      sc_s1_ff <= {left_speaker_short_in, right_speaker_short_in,
                   line_output_short_in};
      sc_s2_ff <= sc_s1_ff;
    end
  end

  // read-only, writes never reach it
  assign short_circuit_status = {sc_s2_ff, 5'h00};

  //////////////////////////////////////////////////////////////////
  // snapshot of all readable registers, register n at byte n-1
  assign cur_word = {output_attenuation_ff, short_circuit_status,
                     transmit_volume_ff, receive_volume_ff,
                     input_mixer_gain_ff, pll_feedback_multiplier_ff,
                     pll_input_divider_ff, filter_pll_loopback_control_ff,
                     power_and_reset_control_ff};

  // handshake word crossing: hold stays still while req differs from ack;
  // a read sees values at most a few link clocks old
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      snap_hold_ff <= 72'h0;
      snap_req_ff <= 1'b0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end
    else
    begin
      ack_s1_ff <= snap_seen_ff;
      ack_s2_ff <= ack_s1_ff;
      if (ack_s2_ff == snap_req_ff)
      begin
        snap_hold_ff <= cur_word;
        snap_req_ff <= ~snap_req_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // control outputs straight from register bits, pll factors and bypass from div_fac_ff, mul_fac_ff and bypass_ff
  assign speaker_drive_enable = power_and_reset_control_ff[`VCR_B_SPK];
  assign line_drive_enable = power_and_reset_control_ff[`VCR_B_LINE];
  assign handset_drive_enable = power_and_reset_control_ff[`VCR_B_HS];
  assign mic_bias_powerdown = power_and_reset_control_ff[`VCR_B_MIC];
  assign chip_sleep = power_and_reset_control_ff[`VCR_B_SLEEP];
  assign highpass_disable = filter_pll_loopback_control_ff[`VCR_B_HPF];
  assign pll_post_div10 = filter_pll_loopback_control_ff[`VCR_B_DIV10];
  assign analog_loopback_select = filter_pll_loopback_control_ff[`VCR_B_ALB];
  assign bitstream_loopback_select = filter_pll_loopback_control_ff[`VCR_B_BLB];
  assign pll_divide_factor = div_fac_ff;
  assign pll_multiply_factor = mul_fac_ff;
  assign pll_bypass = bypass_ff;
  // gain code 00 on the line input is passed as is
  assign line_input_gain = input_mixer_gain_ff[7:6];
  assign line_input_mute = input_mixer_gain_ff[5];
  assign microphone_gain = input_mixer_gain_ff[4:3];
  assign microphone_mute = input_mixer_gain_ff[2];
  assign handset_input_mute = input_mixer_gain_ff[1];
  assign recursive_filter_select = input_mixer_gain_ff[0];
  assign receive_gain = receive_volume_ff[6:2];
  assign line_output_active = receive_volume_ff[1];
  assign handset_output_active = receive_volume_ff[0];
  assign transmit_gain = transmit_volume_ff[6:2];
  assign left_speaker_active = transmit_volume_ff[1];
  assign right_speaker_active = transmit_volume_ff[0];
  assign line_output_attenuation = output_attenuation_ff[3:2];
  assign speaker_output_attenuation = output_attenuation_ff[1:0];
  assign serial_data_out = sout_ff;

  //////////////////////////////////////////////////////////////////
  // link domain reset and snapshot capture
  always_ff @(posedge sclk)
  begin
    lrst_s1_ff <= srst;
    lrst_s2_ff <= lrst_s1_ff;
  end

  always_ff @(posedge sclk)
  begin
    if (lrst_s2_ff)
    begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      snap_seen_ff <= 1'b0;
      snap_l_ff <= 72'h0;
    end
    else
    begin
      req_s1_ff <= snap_req_ff;
      req_s2_ff <= req_s1_ff;
      if (req_s2_ff != snap_seen_ff)
      begin
        snap_l_ff <= snap_hold_ff;
        snap_seen_ff <= req_s2_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // frame receiver; pos is the index of the bit taken at this edge
  assign pos = frame_sync ? 4'd0 : cnt_ff;
  assign in_frm = frame_sync || (state_ff == vcr_pkg::FRM_BUSY);
  assign nxt_shift = {shift_ff[6:0], serial_data_in};

  always_ff @(posedge sclk)
  begin
    if (lrst_s2_ff)
    begin
      state_ff <= vcr_pkg::FRM_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      addr_ff <= 5'h00;
    end
    else
    begin
      shift_ff <= nxt_shift;
      if (frame_sync)
      begin
        state_ff <= vcr_pkg::FRM_BUSY;
        cnt_ff <= 4'd1;
      end
      else
      begin
        unique case (state_ff)
          vcr_pkg::FRM_IDLE: cnt_ff <= 4'h0;
          vcr_pkg::FRM_BUSY:
          begin
            cnt_ff <= cnt_ff + 4'd1;
            if (cnt_ff == `VCR_P_LAST)
              state_ff <= vcr_pkg::FRM_IDLE;
          end
        endcase
      end
      // direction bit then five address bits, msb first
      if (in_frm && (pos == `VCR_P_ADDR))
      begin
        rw_ff <= nxt_shift[5];
        addr_ff <= nxt_shift[4:0];
      end
    end
  end

  // a write is launched only once all eight data bits are in
  always_ff @(posedge sclk)
  begin
    if (lrst_s2_ff)
    begin
      wr_tgl_ff <= 1'b0;
      wr_addr_l_ff <= 5'h00;
      wr_data_l_ff <= 8'h00;
    end
    else if (in_frm && (pos == `VCR_P_LAST) && !rw_ff)
    begin
      wr_addr_l_ff <= addr_ff;
      wr_data_l_ff <= nxt_shift;
      wr_tgl_ff <= ~wr_tgl_ff;
    end
  end

  //////////////////////////////////////////////////////////////////
  // read mux; address zero and unmapped addresses give zero
  always_comb
  begin
    rd_word = 8'h00;
    for (int i = 1; i <= `VCR_NREG; i++)
    begin
      if (addr_ff == 5'(i))
        rd_word = snap_l_ff[8*(i-1) +: 8];
    end
  end

  assign rd_idx = 4'(`VCR_P_RD7 - pos);

  // data msb first in the last eight bit slots of a read frame
  always_ff @(posedge sclk)
  begin
    if (lrst_s2_ff)
      sout_ff <= 1'b0;
    else if (in_frm && rw_ff && (pos >= `VCR_P_RD0) && (pos <= `VCR_P_RD7))
      sout_ff <= rd_word[rd_idx[2:0]];
    else
      sout_ff <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////
  // checks
  a_addr0_inert: assert property (@(posedge clk) disable iff (srst)
    wr_take && (wr_addr_l_ff == `VCR_A_ZERO) |=> $stable(cur_word[71:64])
    && $stable(cur_word[55:0]))
    else $error("write to address zero changed a register");

  a_soft_clear: assert property (@(posedge clk) disable iff (srst)
    soft_rst |=> (power_and_reset_control_ff == `VCR_R_PWR)
    && (input_mixer_gain_ff == `VCR_R_MIX) && (receive_volume_ff == `VCR_R_VOL)
    && pll_bypass)
    else $error("soft reset did not restore registers");

  a_drive_map: assert property (@(posedge clk) disable iff (srst)
    wr_take && (wr_addr_l_ff == `VCR_A_PWR) && !wr_data_l_ff[7]
    |=> ##1 (speaker_drive_enable == $past(wr_data_l_ff[4], 2))
    && (handset_drive_enable == $past(wr_data_l_ff[2], 2)))
    else $error("driver enables do not follow power register");

  a_loop_map: assert property (@(posedge clk) disable iff (srst)
    wr_take && (wr_addr_l_ff == `VCR_A_FPL)
    |=> (bitstream_loopback_select == $past(wr_data_l_ff[1]))
    && (highpass_disable == $past(wr_data_l_ff[4])))
    else $error("second control bits misplaced");

  a_pll_order: assert property (@(posedge clk) disable iff (srst)
    wr_take && (wr_addr_l_ff == `VCR_A_DIV) |=> $stable(pll_divide_factor))
    else $error("divider applied before multiplier write");

  a_pll_plus1: assert property (@(posedge clk) disable iff (srst)
    wr_take && (wr_addr_l_ff == `VCR_A_MUL)
    |=> pll_multiply_factor == ({1'b0, $past(wr_data_l_ff)} + `VCR_F_ONE))
    else $error("multiplier factor not stored value plus one");

  a_pll_bypass: assert property (@(posedge clk) disable iff (srst)
    pll_bypass |-> (pll_divide_factor == `VCR_F_ONE)
    && (pll_multiply_factor == `VCR_F_ONE))
    else $error("bypass with nonzero pll registers");

  a_rsv_zero: assert property (@(posedge clk) disable iff (srst)
    (cur_word[7:5] == 3'h0) && (cur_word[15:13] == 3'h0) && !cur_word[8]
    && !cur_word[47] && !cur_word[55] && (cur_word[60:56] == 5'h00)
    && (cur_word[71:68] == 4'h0))
    else $error("reserved bit reads nonzero");

  a_rd_zero: assert property (@(posedge sclk) disable iff (lrst_s2_ff)
    in_frm && rw_ff && (addr_ff == `VCR_A_ZERO) && (pos >= `VCR_P_RD0)
    |=> !serial_data_out)
    else $error("address zero read nonzero");

  a_frame_wr: assert property (@(posedge sclk) disable iff (lrst_s2_ff)
    in_frm && (pos == `VCR_P_LAST) && !rw_ff |=> wr_tgl_ff != $past(wr_tgl_ff))
    else $error("complete write frame not launched");

  c_soft_rst: cover property (@(posedge clk) disable iff (srst) soft_rst);
  c_pll_set: cover property (@(posedge clk) disable iff (srst)
    wr_take && (wr_addr_l_ff == `VCR_A_MUL) ##1 !pll_bypass);
  c_rd_frame: cover property (@(posedge sclk) disable iff (lrst_s2_ff)
    in_frm && rw_ff && (pos == `VCR_P_RD7));
  c_wr_frame: cover property (@(posedge clk) disable iff (srst)
    wr_take && (wr_addr_l_ff == `VCR_A_RXV));

endmodule

// File: tb/vcr_host.sv
// serial host model: issues one 16-bit control frame per register access
module vcr_host (
  // link
  input wire logic sclk,
  output logic frame_sync,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet link at time zero
  initial
  begin
    frame_sync = 1'b0;
    serial_data_in = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one frame: read/write bit, 5-bit address, two pad bits, 8 data bits, msb first
  task automatic xfer(input logic rw, input logic [4:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] bits;
    bits = {rw, addr, 2'b00, rw ? 8'h00 : wdata};
    rdata = 8'h00;
    for (int i = 0; i < 17; i++)
    begin
      @(posedge sclk);
      #2;
      // read bit launched at this edge, taken once it has settled
      if (i >= 8 && i < 16)
        rdata = {rdata[6:0], serial_data_out};
      if (i < 16)
      begin
        frame_sync = (i == 0);
        serial_data_in = bits[15 - i];
      end
      else
        serial_data_in = ~bits[0]; // no pull on the line: never leave the last bit
    end
  endtask

  // pll update: divider frame, then the multiplier frame straight after
  task automatic pll_set(input logic [7:0] div_less1, input logic [7:0] mul_less1);
    logic [7:0] d;
    xfer(1'b0, 5'h03, div_less1, d);
    xfer(1'b0, 5'h04, mul_less1, d);
  endtask
endmodule

// File: tb/tb_top.sv
// bench for the control register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sclk = 1'b0;
  logic srst = 1'b1;
  logic frame_sync;
  logic serial_data_in;
  logic serial_data_out;
  logic [2:0] short_in = 3'h0;
  logic speaker_drive_enable, line_drive_enable, handset_drive_enable;
  logic mic_bias_powerdown, chip_sleep, highpass_disable, pll_post_div10;
  logic analog_loopback_select, bitstream_loopback_select, pll_bypass;
  logic [8:0] pll_divide_factor, pll_multiply_factor;
  logic [1:0] line_input_gain, microphone_gain, line_output_attenuation;
  logic [1:0] speaker_output_attenuation;
  logic line_input_mute, microphone_mute, handset_input_mute, recursive_filter_select;
  logic [4:0] receive_gain, transmit_gain;
  logic line_output_active, handset_output_active, left_speaker_active, right_speaker_active;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [7:0] rst_v [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h47, 8'h5C, 8'h5C, 8'h00,
                             8'h00};
  logic [4:0] wa [14] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h09, 5'h01, 5'h02, 5'h05,
                          5'h05, 5'h05, 5'h06, 5'h07, 5'h09};
  logic [7:0] wv [14] = '{8'h7F, 8'hFF, 8'hB8, 8'hFF, 8'h83, 8'hF6, 8'h0A, 8'h14, 8'h00,
                          8'hD7, 8'h68, 8'h00, 8'h7C, 8'h0F};

  // system clock 20 ns; link clock 48 ns with its own phase
  always #10 clk = ~clk;
  initial
  begin
    #7;
    forever #24 sclk = ~sclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  vcr_regs vcr_regs_inst (
    .clk(clk), .srst(srst), .sclk(sclk), .frame_sync(frame_sync),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .left_speaker_short_in(short_in[2]), .right_speaker_short_in(short_in[1]),
    .line_output_short_in(short_in[0]), .speaker_drive_enable(speaker_drive_enable),
    .line_drive_enable(line_drive_enable), .handset_drive_enable(handset_drive_enable),
    .mic_bias_powerdown(mic_bias_powerdown), .chip_sleep(chip_sleep),
    .highpass_disable(highpass_disable), .pll_post_div10(pll_post_div10),
    .analog_loopback_select(analog_loopback_select),
    .bitstream_loopback_select(bitstream_loopback_select),
    .pll_divide_factor(pll_divide_factor), .pll_multiply_factor(pll_multiply_factor),
    .pll_bypass(pll_bypass), .line_input_gain(line_input_gain),
    .line_input_mute(line_input_mute), .microphone_gain(microphone_gain),
    .microphone_mute(microphone_mute), .handset_input_mute(handset_input_mute),
    .recursive_filter_select(recursive_filter_select), .receive_gain(receive_gain),
    .line_output_active(line_output_active), .handset_output_active(handset_output_active),
    .transmit_gain(transmit_gain), .left_speaker_active(left_speaker_active),
    .right_speaker_active(right_speaker_active),
    .line_output_attenuation(line_output_attenuation),
    .speaker_output_attenuation(speaker_output_attenuation)
  );

  vcr_host vcr_host_inst (
    .sclk(sclk), .frame_sync(frame_sync), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // writable bits of each defined address
  function automatic logic [7:0] wmask(input logic [4:0] a);
    case (a)
      5'h01: return 8'h1F;
      5'h02: return 8'h1E;
      5'h03, 5'h04, 5'h05: return 8'hFF;
      5'h06, 5'h07: return 8'h7F;
      5'h09: return 8'h0F;
      default: return 8'h00;
    endcase
  endfunction

  // write, then give the clock-domain crossing time to land
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] d;
    vcr_host_inst.xfer(1'b0, a, v, d);
    repeat (10) @(posedge clk);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] v;
    vcr_host_inst.xfer(1'b1, a, 8'h00, v);
    chk($sformatf("read of address %h", a), {1'b0, exp}, {1'b0, v});
  endtask

  // control outputs that follow register a holding v
  task automatic chk_fields(input logic [4:0] a, input logic [7:0] v);
    case (a)
      5'h01: chk("power outputs", {4'h0, v[4:0]}, {4'h0, speaker_drive_enable,
        line_drive_enable, handset_drive_enable, mic_bias_powerdown, chip_sleep});
      5'h02: chk("filter outputs", {5'h0, v[4:1]}, {5'h0, highpass_disable, pll_post_div10,
        analog_loopback_select, bitstream_loopback_select});
      5'h05: chk("mixer outputs", {1'b0, v}, {1'b0, line_input_gain, line_input_mute,
        microphone_gain, microphone_mute, handset_input_mute, recursive_filter_select});
      5'h06: chk("receive outputs", {2'h0, v[6:0]}, {2'h0, receive_gain, line_output_active,
        handset_output_active});
      5'h07: chk("transmit outputs", {2'h0, v[6:0]}, {2'h0, transmit_gain,
        left_speaker_active, right_speaker_active});
      5'h09: chk("attenuation outputs", {5'h0, v[3:0]}, {5'h0, line_output_attenuation,
        speaker_output_attenuation});
      default: ;
    endcase
  endtask

  task automatic chk_pll(input logic [8:0] d, input logic [8:0] m, input logic b);
    chk("pll divide factor", d, pll_divide_factor);
    chk("pll multiply factor", m, pll_multiply_factor);
    chk("pll bypass", {8'h0, b}, {8'h0, pll_bypass});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // every register and output at its reset value
  task automatic t_reset_values();
    for (logic [4:0] a = 5'h00; a < 5'h0A; a++)
    begin
      rd_chk(a, rst_v[a]);
      chk_fields(a, rst_v[a]);
    end
    chk_pll(9'h001, 9'h001, 1'b1);
  endtask

  // each field written and read back, mixer, receive and transmit bits both ways; reserved bits written as ones must read zero
  task automatic t_fields();
    for (int i = 0; i < 14; i++)
    begin
      wr(wa[i], wv[i]);
      chk_fields(wa[i], wv[i] & wmask(wa[i]));
      rd_chk(wa[i], wv[i] & wmask(wa[i]));
    end
  endtask

  // a write to address zero leaves the attenuation register at 09 unchanged; address zero and an undefined address read zero
  task automatic t_refused();
    wr(5'h00, 8'hFF);
    rd_chk(5'h00, 8'h00);
    chk_fields(5'h09, 8'h0F);
    rd_chk(5'h09, 8'h0F);
    rd_chk(5'h1F, 8'h00);
  endtask

  // short detectors show live in the status bits
  task automatic t_status();
    @(posedge clk);
    #2 short_in = 3'b101;
    repeat (10) @(posedge clk);
    wr(5'h08, 8'hFF);
    rd_chk(5'h08, 8'hA0);
    @(posedge clk);
    #2 short_in = 3'b010;
    repeat (10) @(posedge clk);
    rd_chk(5'h08, 8'h40);
    @(posedge clk);
    #2 short_in = 3'b000;
    repeat (10) @(posedge clk);
  endtask

  // factors are stored minus one; both zero bypasses the loop
  task automatic t_pll();
    vcr_host_inst.pll_set(8'h00, 8'h04);
    repeat (10) @(posedge clk);
    chk_pll(9'h001, 9'h005, 1'b0);
    vcr_host_inst.pll_set(8'h00, 8'h00);
    repeat (10) @(posedge clk);
    chk_pll(9'h001, 9'h001, 1'b1);
    vcr_host_inst.pll_set(8'h09, 8'hC7);
    repeat (10) @(posedge clk);
    chk_pll(9'h00A, 9'h0C8, 1'b0);
    rd_chk(5'h03, 8'h09);
    rd_chk(5'h04, 8'hC7);
  endtask

  // soft reset bit returns everything to reset and reads back zero
  task automatic t_soft_reset();
    wr(5'h02, 8'h1E);
    wr(5'h01, 8'h9F);
    chk_pll(9'h001, 9'h001, 1'b1);
    for (logic [4:0] a = 5'h01; a < 5'h0A; a++)
    begin
      rd_chk(a, rst_v[a]);
      chk_fields(a, rst_v[a]);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    #2 srst = 1'b0;
    repeat (40) @(posedge clk);
    t_reset_values();
    t_fields();
    t_refused();
    t_status();
    t_pll();
    t_soft_reset();
    final_report();
  end

  // watchdog, well past the expected run of about 60 us
  initial
  begin
    #400us;
    n_mismatch++;
    $display("ERROR watchdog expected finish seen timeout");
    final_report();
  end
endmodule
